//--- logic/nec_pkg.sv
// Constants, register map and bus state codes for the NAND ECC control and status block.
// Assumes a 32-bit register slave with byte addresses and registers on aligned words.
package nec_pkg;

    localparam int NEC_DATA_W = 32;
    localparam int NEC_CNT_W = 7;

    localparam logic [7:0] NEC_OFF_DATA_CNT = 8'h00;
    localparam logic [7:0] NEC_OFF_CTRL = 8'h08;
    localparam logic [7:0] NEC_OFF_THRES = 8'h10;
    localparam logic [7:0] NEC_OFF_CORR = 8'h18;
    localparam logic [7:0] NEC_OFF_IRQ_EN = 8'h20;
    localparam logic [7:0] NEC_OFF_IRQ_STAT = 8'h24;
    localparam logic [7:0] NEC_OFF_CNT_CLR = 8'h28;
    localparam logic [7:0] NEC_OFF_SPARE_CNT = 8'h2c;

    localparam int NEC_CTRL_NO_PARITY = 17;
    localparam int NEC_CTRL_BASE_1K = 16;
    localparam int NEC_CTRL_ECC_EN = 8;
    localparam int NEC_CTRL_ERR_MASK = 0;

    localparam int NEC_IEN_SPARE_ALARM = 3;
    localparam int NEC_IEN_SPARE_FAIL = 2;
    localparam int NEC_IEN_DATA_ALARM = 1;
    localparam int NEC_IEN_DATA_FAIL = 0;

    localparam int NEC_IST_SPARE_ALARM = 24;
    localparam int NEC_IST_SPARE_FAIL = 16;
    localparam int NEC_IST_DATA_ALARM = 8;
    localparam int NEC_IST_DATA_FAIL = 0;

    localparam int NEC_CLR_SPARE_CNT = 8;
    localparam int NEC_CLR_DATA_CNT = 0;

    localparam logic [31:0] NEC_CTRL_RW_MASK = 32'h0003_0101;
    localparam logic [31:0] NEC_LEVEL_RW_MASK = 32'h0000_007f;
    localparam logic [31:0] NEC_IEN_RW_MASK = 32'h0000_000f;
    localparam logic [31:0] NEC_REG_RESET = 32'h0000_0000;

    localparam logic [1:0] NEC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] NEC_HSIZE_BYTE = 3'h0;
    localparam logic [2:0] NEC_HSIZE_HALF = 3'h1;

    typedef enum logic [2:0] {
        NEC_BUS_IDLE = 3'b001,
        NEC_BUS_WRITE = 3'b010,
        NEC_BUS_READ = 3'b100
    } nec_bus_st_t;

endpackage

//--- logic/nec_region_if.sv
// Interface between the register side and one region's event tracker.
// Assumes both ends share clk_sys; it carries levels and one-cycle pulses only.
`timescale 1ns/1ps
interface nec_region_if #(parameter int CNT_W = 7);
    logic err_valid;
    logic [CNT_W-1:0] err_bits;
    logic fix_fail;
    logic [CNT_W-1:0] alarm_level;
    logic count_wipe;
    logic clr_alarm;
    logic clr_fail;
    logic alarm_flag;
    logic fail_flag;
    logic [CNT_W-1:0] worst_count;

    modport trk (
        input err_valid,
        input err_bits,
        input fix_fail,
        input alarm_level,
        input count_wipe,
        input clr_alarm,
        input clr_fail,
        output alarm_flag,
        output fail_flag,
        output worst_count
    );

    modport ctl (
        output err_valid,
        output err_bits,
        output fix_fail,
        output alarm_level,
        output count_wipe,
        output clr_alarm,
        output clr_fail,
        input alarm_flag,
        input fail_flag,
        input worst_count
    );
endinterface

//--- logic/nec_region_track.sv
// Per-region tracker: threshold flag, correction fail flag and worst error count.
// Assumes one-cycle event pulses on clk_sys; a new event wins over a clear in the same cycle.
`timescale 1ns/1ps
module nec_region_track #(
    parameter int CNT_W = 7
) (
    input wire logic clk_sys,
    input wire logic rst,
    nec_region_if.trk rg
);
    logic alarm_q;
    logic alarm_d;
    logic fail_q;
    logic fail_d;
    logic [CNT_W-1:0] worst_q;
    logic [CNT_W-1:0] worst_d;
    wire logic hit;
    wire logic bigger;
    wire logic [CNT_W-1:0] base_cnt;

    // Level 0 stands for one bit, so reaching it means exceeding the raw field.
    assign hit = rg.err_valid && (rg.err_bits > rg.alarm_level);
    assign alarm_d = hit || (alarm_q && !rg.clr_alarm);
    assign fail_d = rg.fix_fail || (fail_q && !rg.clr_fail);
    assign base_cnt = rg.count_wipe ? '0 : worst_q;
    assign bigger = rg.err_valid && (rg.err_bits > base_cnt);
    assign worst_d = bigger ? rg.err_bits : base_cnt;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            alarm_q <= 1'b0;
            fail_q <= 1'b0;
            worst_q <= '0;
        end else begin
            alarm_q <= alarm_d;
            fail_q <= fail_d;
            worst_q <= worst_d;
        end
    end

    assign rg.alarm_flag = alarm_q;
    assign rg.fail_flag = fail_q;
    assign rg.worst_count = worst_q;
endmodule

//--- logic/nec_ecc_ctrl.sv
// Top of the ECC control and status block: AHB-lite register slave, control outputs to the
// codec and sector path, and event tracking for the data and spare regions.
// Assumes every input is synchronous to clk_sys and the bus hready returns this slave's hreadyout.
`timescale 1ns/1ps
module nec_ecc_ctrl import nec_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int CNT_W = NEC_CNT_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic data_err_valid,
    input wire logic [CNT_W-1:0] data_err_bits,
    input wire logic data_fix_fail,
    input wire logic spare_err_valid,
    input wire logic [CNT_W-1:0] spare_err_bits,
    input wire logic spare_fix_fail,
    input wire logic [CNT_W-1:0] spare_alarm_level,
    output logic ecc_active,
    output logic base_1k,
    output logic sectors_packed,
    output logic data_block_bad,
    output logic [CNT_W-1:0] data_fix_strength,
    output logic [CNT_W-1:0] data_alarm_level,
    output logic ecc_irq
);
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
        $error("nec_ecc_ctrl: ADDR_W must lie between 6 and 32");
    end
    if (CNT_W < 5 || CNT_W > NEC_CNT_W) begin : g_bad_cnt
        $error("nec_ecc_ctrl: CNT_W must lie between 5 and 7");
    end

    nec_region_if #(.CNT_W(CNT_W)) data_rg ();
    nec_region_if #(.CNT_W(CNT_W)) spare_rg ();

    nec_bus_st_t st_q;
    nec_bus_st_t st_d;
    logic [7:0] dp_addr_q;
    logic [31:0] wmask_q;
    logic [31:0] wmask_d;
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] thres_q;
    logic [31:0] thres_d;
    logic [31:0] corr_q;
    logic [31:0] corr_d;
    logic [31:0] ien_q;
    logic [31:0] ien_d;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic ecc_active_q;
    logic base_1k_q;
    logic sectors_packed_q;
    logic data_block_bad_q;
    logic [CNT_W-1:0] data_fix_strength_q;
    logic [CNT_W-1:0] data_alarm_level_q;
    logic ecc_irq_q;

    wire logic take;
    wire logic [7:0] ap_addr;
    wire logic [3:0] lanes;
    wire logic wr_en;
    wire logic rd_en;
    wire logic sel_ctrl;
    wire logic sel_thres;
    wire logic sel_corr;
    wire logic sel_ien;
    wire logic sel_stat;
    wire logic sel_clr;
    wire logic [31:0] wr_bits;
    logic [31:0] stat_word;
    wire logic [3:0] flag_vec;
    wire logic [31:0] rd_word;
    wire logic ecc_on_now;

    // Address phase: a NONSEQ or SEQ transfer is taken while hready is high.
    assign take = hsel && hready && htrans[1];
    assign ap_addr = 8'(haddr);

    // Byte lanes from transfer size and low address bits.
    assign lanes = (hsize == NEC_HSIZE_BYTE) ? (4'h1 << ap_addr[1:0]) :
                   (hsize == NEC_HSIZE_HALF) ? (ap_addr[1] ? 4'hc : 4'h3) : 4'hf;
    assign wmask_d = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};

    always_comb begin
        st_d = NEC_BUS_IDLE;
        case (st_q)
            NEC_BUS_IDLE,
            NEC_BUS_WRITE: begin
                if (take) begin
                    st_d = hwrite ? NEC_BUS_WRITE : NEC_BUS_READ;
                end
            end
            NEC_BUS_READ: begin
                st_d = NEC_BUS_IDLE;
            end
            default: begin
                st_d = NEC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= NEC_BUS_IDLE;
            dp_addr_q <= 8'h00;
            wmask_q <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
            if (take) begin
                dp_addr_q <= {ap_addr[7:2], 2'h0};
                wmask_q <= wmask_d;
            end
        end
    end

    // Data phase decode.
    assign wr_en = (st_q == NEC_BUS_WRITE);
    assign rd_en = (st_q == NEC_BUS_READ);
    assign sel_ctrl = wr_en && (dp_addr_q == NEC_OFF_CTRL);
    assign sel_thres = wr_en && (dp_addr_q == NEC_OFF_THRES);
    assign sel_corr = wr_en && (dp_addr_q == NEC_OFF_CORR);
    assign sel_ien = wr_en && (dp_addr_q == NEC_OFF_IRQ_EN);
    assign sel_stat = wr_en && (dp_addr_q == NEC_OFF_IRQ_STAT);
    assign sel_clr = wr_en && (dp_addr_q == NEC_OFF_CNT_CLR);
    assign wr_bits = hwdata & wmask_q;

    // Byte-lane merge of each writable register; reserved bits stay zero.
    assign ctrl_d = ((ctrl_q & ~wmask_q) | wr_bits) & NEC_CTRL_RW_MASK;
    assign thres_d = ((thres_q & ~wmask_q) | wr_bits) & NEC_LEVEL_RW_MASK;
    assign corr_d = ((corr_q & ~wmask_q) | wr_bits) & NEC_LEVEL_RW_MASK;
    assign ien_d = ((ien_q & ~wmask_q) | wr_bits) & NEC_IEN_RW_MASK;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_q <= NEC_REG_RESET;
            thres_q <= NEC_REG_RESET;
            corr_q <= NEC_REG_RESET;
            ien_q <= NEC_REG_RESET;
        end else begin
            if (sel_ctrl) begin
                ctrl_q <= ctrl_d;
            end
            if (sel_thres) begin
                thres_q <= thres_d;
            end
            if (sel_corr) begin
                corr_q <= corr_d;
            end
            if (sel_ien) begin
                ien_q <= ien_d;
            end
        end
    end

    // The enable only counts while sectors keep room for parity.
    assign ecc_on_now = ctrl_q[NEC_CTRL_ECC_EN] && !ctrl_q[NEC_CTRL_NO_PARITY];

    // Region trackers; events are taken only while the engine is really on.
    assign data_rg.err_valid = data_err_valid && ecc_on_now;
    assign data_rg.err_bits = data_err_bits;
    assign data_rg.fix_fail = data_fix_fail && ecc_on_now;
    assign data_rg.alarm_level = thres_q[CNT_W-1:0];
    assign data_rg.count_wipe = sel_clr && wr_bits[NEC_CLR_DATA_CNT];
    assign data_rg.clr_alarm = sel_stat && wr_bits[NEC_IST_DATA_ALARM];
    assign data_rg.clr_fail = sel_stat && wr_bits[NEC_IST_DATA_FAIL];

    // The blocking mask plays no part in any spare signal.
    assign spare_rg.err_valid = spare_err_valid && ecc_on_now;
    assign spare_rg.err_bits = spare_err_bits;
    assign spare_rg.fix_fail = spare_fix_fail && ecc_on_now;
    assign spare_rg.alarm_level = spare_alarm_level;
    assign spare_rg.count_wipe = sel_clr && wr_bits[NEC_CLR_SPARE_CNT];
    assign spare_rg.clr_alarm = sel_stat && wr_bits[NEC_IST_SPARE_ALARM];
    assign spare_rg.clr_fail = sel_stat && wr_bits[NEC_IST_SPARE_FAIL];

    nec_region_track #(.CNT_W(CNT_W)) u_data_trk (
        .clk_sys(clk_sys),
        .rst(rst),
        .rg(data_rg.trk)
    );

    nec_region_track #(.CNT_W(CNT_W)) u_spare_trk (
        .clk_sys(clk_sys),
        .rst(rst),
        .rg(spare_rg.trk)
    );

    // Status word with flags at their fixed bit positions.
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[NEC_IST_SPARE_ALARM] = spare_rg.alarm_flag;
        stat_word[NEC_IST_SPARE_FAIL] = spare_rg.fail_flag;
        stat_word[NEC_IST_DATA_ALARM] = data_rg.alarm_flag;
        stat_word[NEC_IST_DATA_FAIL] = data_rg.fail_flag;
    end

    // Flag order matches the enable register bit order.
    assign flag_vec = {spare_rg.alarm_flag, spare_rg.fail_flag, data_rg.alarm_flag, data_rg.fail_flag};

    // Read mux; the clear register and unmapped words read as zero.
    assign rd_word = (dp_addr_q == NEC_OFF_DATA_CNT) ? 32'(data_rg.worst_count) :
                     (dp_addr_q == NEC_OFF_CTRL) ? ctrl_q :
                     (dp_addr_q == NEC_OFF_THRES) ? thres_q :
                     (dp_addr_q == NEC_OFF_CORR) ? corr_q :
                     (dp_addr_q == NEC_OFF_IRQ_EN) ? ien_q :
                     (dp_addr_q == NEC_OFF_IRQ_STAT) ? stat_word :
                     (dp_addr_q == NEC_OFF_SPARE_CNT) ? 32'(spare_rg.worst_count) :
                     32'h0000_0000;

    // Reads take one wait state so that a write just before is already visible.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
        end else begin
            hreadyout_q <= !(take && !hwrite);
            if (rd_en) begin
                hrdata_q <= rd_word;
            end
        end
    end

    // Control outputs, registered one cycle after the register that feeds them.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ecc_active_q <= 1'b0;
            base_1k_q <= 1'b0;
            sectors_packed_q <= 1'b0;
            data_block_bad_q <= 1'b0;
            data_fix_strength_q <= '0;
            data_alarm_level_q <= '0;
            ecc_irq_q <= 1'b0;
        end else begin
            ecc_active_q <= ecc_on_now;
            base_1k_q <= ctrl_q[NEC_CTRL_BASE_1K];
            sectors_packed_q <= ctrl_q[NEC_CTRL_NO_PARITY];
            data_block_bad_q <= ecc_on_now && !ctrl_q[NEC_CTRL_ERR_MASK];
            data_fix_strength_q <= corr_q[CNT_W-1:0];
            data_alarm_level_q <= thres_q[CNT_W-1:0];
            ecc_irq_q <= |(flag_vec & ien_q[3:0]);
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign ecc_active = ecc_active_q;
    assign base_1k = base_1k_q;
    assign sectors_packed = sectors_packed_q;
    assign data_block_bad = data_block_bad_q;
    assign data_fix_strength = data_fix_strength_q;
    assign data_alarm_level = data_alarm_level_q;
    assign ecc_irq = ecc_irq_q;
endmodule

//--- test/nec_ecc_checker.sv
// Checker for the ECC control block, bound to its top module.
// Assumes the bus hready is looped back from hreadyout.
`timescale 1ns/1ps
module nec_ecc_checker import nec_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 7
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic data_err_valid,
    input wire logic data_fix_fail,
    input wire logic spare_err_valid,
    input wire logic spare_fix_fail,
    input wire logic ecc_active,
    input wire logic base_1k,
    input wire logic sectors_packed,
    input wire logic data_block_bad,
    input wire logic [CNT_W-1:0] data_fix_strength,
    input wire logic [CNT_W-1:0] data_alarm_level,
    input wire logic ecc_irq
);
    logic [3:0] quiet_q;
    logic [3:0] quiet_d;
    wire take = hsel && hready && htrans[1];
    wire act = take || data_err_valid || data_fix_fail || spare_err_valid || spare_fix_fail;
    wire wr_w = take && hwrite && hsize == 3'h2;
    assign quiet_d = act ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            quiet_q <= 4'hf;
        end else begin
            quiet_q <= quiet_d;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence rd_take;
        take && !hwrite;
    endsequence
    sequence rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    read_wait_a: assert property (rd_take |=> rd_answer)
        else $error("read answer late");
    ready_once_a: assert property (!hreadyout |=> hreadyout)
        else $error("wait state too long");
    ctrl_follow_a: assert property (wr_w && haddr[7:2] == 6'h02 |=> ##2
        base_1k == $past(hwdata[16], 2) && sectors_packed == $past(hwdata[17], 2))
        else $error("size or packing wrong");
    active_follow_a: assert property (wr_w && haddr[7:2] == 6'h02 |=> ##2
        ecc_active == ($past(hwdata[8], 2) && !$past(hwdata[17], 2)) &&
        data_block_bad == (ecc_active && !$past(hwdata[0], 2)))
        else $error("enable or blocking wrong");
    level_follow_a: assert property (wr_w && haddr[7:2] == 6'h04 |=> ##2
        data_alarm_level == $past(hwdata[CNT_W-1:0], 2))
        else $error("alarm level wrong");
    strength_follow_a: assert property (wr_w && haddr[7:2] == 6'h06 |=> ##2
        data_fix_strength == $past(hwdata[CNT_W-1:0], 2))
        else $error("fix strength wrong");
    gate_packed_a: assert property (sectors_packed |-> !ecc_active)
        else $error("active while packed");
    block_mask_a: assert property (data_block_bad |-> ecc_active)
        else $error("blocking while inactive");
    irq_cause_a: assert property ($changed(ecc_irq) |-> quiet_q < 4'h4)
        else $error("interrupt moved without cause");
endmodule
bind nec_ecc_ctrl nec_ecc_checker #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) nec_ecc_checker_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .data_err_valid(data_err_valid),
    .data_fix_fail(data_fix_fail),
    .spare_err_valid(spare_err_valid),
    .spare_fix_fail(spare_fix_fail),
    .ecc_active(ecc_active),
    .base_1k(base_1k),
    .sectors_packed(sectors_packed),
    .data_block_bad(data_block_bad),
    .data_fix_strength(data_fix_strength),
    .data_alarm_level(data_alarm_level),
    .ecc_irq(ecc_irq)
);

//--- test/nec_ecc_src.sv
// Decoder-side event source feeding sector results into the block.
// Assumes bench requests are taken at the rising clk_sys edge.
`timescale 1ns/1ps
module nec_ecc_src (
    input wire logic clk_sys,
    input wire logic fire,
    input wire logic spare,
    input wire logic fail,
    input wire logic [6:0] bits,
    output logic data_err_valid,
    output logic [6:0] data_err_bits,
    output logic data_fix_fail,
    output logic spare_err_valid,
    output logic [6:0] spare_err_bits,
    output logic spare_fix_fail
);
    initial begin
        {data_err_valid, data_fix_fail, spare_err_valid, spare_fix_fail} = 4'h0;
        {data_err_bits, spare_err_bits} = 14'h0;
    end
    always @(posedge clk_sys) begin
        data_err_valid <= fire && !spare && !fail;
        spare_err_valid <= fire && spare && !fail;
        data_fix_fail <= fire && !spare && fail;
        spare_fix_fail <= fire && spare && fail;
        data_err_bits <= (fire && !spare) ? bits : ~data_err_bits;
        spare_err_bits <= (fire && spare) ? bits : ~spare_err_bits;
    end
endmodule

//--- test/testbench.sv
// Self-checking bench for the ECC control block with a decoder-side event source.
// Assumes a 40 MHz clk_sys and the bus ready looped back from the slave.
`timescale 1ns/1ps
module testbench import nec_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, ecc_active, base_1k, sectors_packed, data_block_bad, ecc_irq;
    logic data_err_valid, data_fix_fail, spare_err_valid, spare_fix_fail;
    logic [6:0] data_err_bits, spare_err_bits, data_fix_strength, data_alarm_level;
    logic fire = 1'b0, spare = 1'b0, fail = 1'b0;
    logic [6:0] bits = 7'h00;
    logic [6:0] spare_alarm_level = 7'h01;
    logic [6:0] caps [3] = '{7'h03, 7'h07, 7'h0f};
    logic [31:0] seed = 32'h34541d99;
    logic [31:0] r, ctrl_m = 0, thr_m = 0, ien_m = 0, ist_m = 0, dcnt_m = 0, scnt_m = 0;
    logic [31:0] exp_q [$];
    logic rd_ph = 1'b0;
    int fails = 0;
    int total_checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    nec_ecc_ctrl nec_ecc_ctrl_inst (
        .clk_sys(clk_sys),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .data_err_valid(data_err_valid),
        .data_err_bits(data_err_bits),
        .data_fix_fail(data_fix_fail),
        .spare_err_valid(spare_err_valid),
        .spare_err_bits(spare_err_bits),
        .spare_fix_fail(spare_fix_fail),
        .spare_alarm_level(spare_alarm_level),
        .ecc_active(ecc_active),
        .base_1k(base_1k),
        .sectors_packed(sectors_packed),
        .data_block_bad(data_block_bad),
        .data_fix_strength(data_fix_strength),
        .data_alarm_level(data_alarm_level),
        .ecc_irq(ecc_irq)
    );
    nec_ecc_src nec_ecc_src_inst (
        .clk_sys(clk_sys),
        .fire(fire),
        .spare(spare),
        .fail(fail),
        .bits(bits),
        .data_err_valid(data_err_valid),
        .data_err_bits(data_err_bits),
        .data_fix_fail(data_fix_fail),
        .spare_err_valid(spare_err_valid),
        .spare_err_bits(spare_err_bits),
        .spare_fix_fail(spare_fix_fail)
    );
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
        @(negedge clk_sys);
        {hsel, htrans, hwrite, haddr, hsize} = {1'b1, 2'h2, 1'b1, a, sz};
        @(negedge clk_sys);
        {hsel, htrans, hwdata} = {1'b0, 2'h0, d};
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge clk_sys);
        {hsel, htrans, hwrite, haddr, hsize} = {1'b1, 2'h2, 1'b0, a, 3'h2};
        exp_q.push_back(e);
        @(negedge clk_sys);
        {hsel, htrans} = 3'h0;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic ev(input logic s, input logic f, input logic [6:0] b);
        @(negedge clk_sys);
        {fire, spare, fail, bits} = {1'b1, s, f, b};
        @(negedge clk_sys);
        fire = 1'b0;
        repeat (3) @(negedge clk_sys);
        if (ctrl_m[8] && !ctrl_m[17]) begin
            if (f) begin
                ist_m[s ? 16 : 0] = 1'b1;
            end else if (s) begin
                ist_m[24] = ist_m[24] | (b > spare_alarm_level);
                scnt_m = (b > scnt_m[6:0]) ? {25'h0, b} : scnt_m;
            end else begin
                ist_m[8] = ist_m[8] | (b > thr_m[6:0]);
                dcnt_m = (b > dcnt_m[6:0]) ? {25'h0, b} : dcnt_m;
            end
        end
    endtask
    task automatic check_state();
        rd(8'h24, ist_m);
        rd(8'h00, dcnt_m);
        rd(8'h2c, scnt_m);
        chk({31'h0, ecc_irq}, {31'h0, |({ist_m[24], ist_m[16], ist_m[8], ist_m[0]} & ien_m[3:0])}, "ecc_irq");
        chk({31'h0, hresp}, 32'h0, "hresp");
    endtask
    always @(posedge clk_sys) begin
        if (rd_ph && hreadyout === 1'b1) begin
            chk(hrdata, exp_q.pop_front(), "hrdata");
        end
        if (hreadyout === 1'b1) begin
            rd_ph <= hsel && htrans[1] && !hwrite;
        end
    end
    initial begin
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        for (int i = 0; i < 12; i++) begin
            rd(8'(i * 4), 32'h0);
        end
        for (int i = 0; i < 12; i++) begin
            r = rnd() | 32'h100;
            ctrl_m = r & NEC_CTRL_RW_MASK;
            wr(8'h08, r, 3'h2);
            rd(8'h08, ctrl_m);
            r = rnd();
            thr_m = r & NEC_LEVEL_RW_MASK;
            wr(8'h10, r, 3'h2);
            rd(8'h10, thr_m);
            wr(8'h18, {25'h0, caps[i % 3]}, 3'h2);
            rd(8'h18, {25'h0, caps[i % 3]});
            r = rnd();
            ien_m = r & NEC_IEN_RW_MASK;
            wr(8'h20, r, 3'h2);
            rd(8'h20, ien_m);
            spare_alarm_level = r[14:8];
            for (int k = 0; k < 4; k++) begin
                r = rnd();
                ev(r[0], r[1] & r[2], (r[0] ? spare_alarm_level : thr_m[6:0]) + 7'(r[5:4]) - 7'h1);
            end
            check_state();
            r = rnd();
            wr(8'h24, r, 3'h2);
            ist_m = ist_m & ~r;
            wr(8'h28, r, 3'h2);
            dcnt_m = r[0] ? 32'h0 : dcnt_m;
            scnt_m = r[8] ? 32'h0 : scnt_m;
            wr(8'h00, r, 3'h2);
            wr(8'h2c, r, 3'h2);
            check_state();
        end
        ctrl_m = 32'h101;
        wr(8'h08, ctrl_m, 3'h2);
        ev(1'b1, 1'b1, 7'h0);
        ev(1'b0, 1'b1, 7'h0);
        wr(8'h26, 32'h0101_0101, 3'h0);
        ist_m[16] = 1'b0;
        check_state();
        give_verdict();
    end
    initial begin
        #2ms;
        fails++;
        give_verdict();
    end
endmodule
